/* cbtr_pkg.sv */
`default_nettype none
package cbtr_pkg;
  // ==========================================================
  // Field widths and fixed timing
  localparam int CBTR_PRS_W     = 8;    // Prescaler field width
  localparam int CBTR_SEG_W     = 4;    // Segment length field width
  localparam int CBTR_CNT_W     = 6;    // Quantum counter width
  localparam int CBTR_IPT_TQ    = 2;    // Information processing time, quanta
  // ==========================================================
  // Reset values
  localparam logic CBTR_RECESSIVE = 1'b1;
  localparam logic [7:0] CBTR_PRS_RST = 8'h00;
  localparam logic [5:0] CBTR_CNT_RST = 6'h00;
  localparam logic [5:0] CBTR_SYNC_LEN = 6'h01;  // Sync segment, one quantum
  // Bit segment states
  typedef enum logic [1:0] {
    CBTR_SYNC,
    CBTR_PROP,
    CBTR_PH1,
    CBTR_PH2
  } cbtr_seg_e;
endpackage
`default_nettype wire

/* cbtr_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module cbtr_prescaler
  import cbtr_pkg::*;
#(
  parameter int PRS_W = CBTR_PRS_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [PRS_W-1:0] div_i,
  input  wire logic             restart_i,
  output logic                  tq_tick_o
);
  logic [PRS_W-1:0] cnt_r;

  // Refuse an empty divider
  if (PRS_W < 1) begin : g_bad_width
    $error("cbtr_prescaler: unsupported width");
  end

  // ==========================================================
  // Quantum divider: one tick every div_i+1 clocks
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r     <= '0;
      tq_tick_o <= 1'b0;
    end else if (restart_i) begin  // see R15
      cnt_r     <= '0;
      tq_tick_o <= 1'b0;
    end else if (cnt_r >= div_i) begin
      cnt_r     <= '0;
      tq_tick_o <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 1'b1;
      tq_tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* cbtr_bit_timing.sv */
// Contract
// R1 - Bit is sync, prop, phase1, phase2 quanta
// R2 - Hard sync on SOF, resync in frame
// R3 - Transmit level changes at sync start
// R4 - Edge outside sync is phase error
// R5 - Propagation segment length is configurable
// R6 - Phase 1 may be lengthened
// R7 - Sample bus once at phase1/phase2 boundary
// R8 - Phase 2 shortenable, ipt to phase1
// R9 - Processing time two quanta, phase2 minimum
// R10 - Late edge lengthens phase 1; code only for an edge in phase 1, one in prop is not corrected
// R11 - Early edge shortens phase 2
// R12 - Correction limited to jump width
// R13 - Software keeps jump width within phase2
// R14 - Sample point set by segment lengths
// R15 - Prescaled quantum, counter restarts each bit
`timescale 1ns/1ps
`default_nettype none
module cbtr_bit_timing
  import cbtr_pkg::*;
#(
  parameter int PRS_W = CBTR_PRS_W,
  parameter int SEG_W = CBTR_SEG_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             enable_i,
  input  wire logic [PRS_W-1:0] prescale_i,
  input  wire logic [SEG_W-1:0] prop_seg_i,
  input  wire logic [SEG_W-1:0] phase1_seg_i,
  input  wire logic [SEG_W-1:0] phase2_seg_i,
  input  wire logic [SEG_W-1:0] sjw_i,
  input  wire logic             in_frame_i,
  input  wire logic             tx_bit_i,
  input  wire logic             rx_pin_i,
  output logic                  tx_pin_o,
  output logic                  rx_bit_o,
  output logic                  sample_o,
  output logic                  bit_start_o,
  output logic                  phase_err_o,
  output logic                  hard_sync_o,
  output logic                  cfg_err_o
);
  // Refuse widths the quantum counter cannot hold
  if (SEG_W < 2 || SEG_W > CBTR_CNT_W - 1 || PRS_W < 1) begin : g_bad_width
    $error("cbtr_bit_timing: unsupported width");
  end

  logic rx_meta_r, rx_sync_r, rx_prev_r;
  logic [CBTR_CNT_W-1:0] cnt_r, seg_len_r;
  logic [CBTR_CNT_W-1:0] seg_len_nxt;
  cbtr_seg_e seg_r;
  logic tq_tick, fall_edge, hs_req, in_sync_seg, resync, seg_end;
  logic [CBTR_CNT_W-1:0] len_eff;

  // ==========================================================
  // Pin synchroniser and edge detect
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_meta_r <= CBTR_RECESSIVE;
      rx_sync_r <= CBTR_RECESSIVE;
      rx_prev_r <= CBTR_RECESSIVE;
    end else begin
      rx_meta_r <= rx_pin_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end
  assign fall_edge = rx_prev_r & ~rx_sync_r & enable_i;
  // Hard sync only on the SOF edge, outside a frame
  assign hs_req = fall_edge & ~in_frame_i;  // see R2
  assign in_sync_seg = (seg_r == CBTR_SYNC);

  // ==========================================================
  // Quantum tick
  cbtr_prescaler #(.PRS_W(PRS_W)) u_prs (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .div_i      (prescale_i),
    .restart_i  (hs_req | ~enable_i),
    .tq_tick_o  (tq_tick)
  );

  function automatic logic [CBTR_CNT_W-1:0] ext(input logic [SEG_W-1:0] v);
    ext = CBTR_CNT_W'(v);
  endfunction

  // Next segment length on resync edge
  always_comb begin
    seg_len_nxt = seg_len_r;
    if (seg_r == CBTR_PH1 || seg_r == CBTR_PROP) begin
      // Late edge: lengthen phase 1 by elapsed quanta, at most sjw
      if (seg_r == CBTR_PH1)  // see R6, R10
        seg_len_nxt = seg_len_r + ((cnt_r + 1'b1 < ext(sjw_i)) ?
                      cnt_r + 1'b1 : ext(sjw_i));  // see R12
    end else if (seg_r == CBTR_PH2) begin
      // Early edge: cut phase 2, by at most sjw
      seg_len_nxt = ((seg_len_r - cnt_r) <= ext(sjw_i)) ?
                    cnt_r : seg_len_r - ext(sjw_i);  // see R11, R12
    end
  end

  // In-frame edge outside the sync segment; one in phase 1 or phase 2 corrects the running segment
  assign resync  = fall_edge & in_frame_i & ~in_sync_seg;  // see R4
  // A tick in the edge cycle is counted against the corrected length,
  // so no quantum is lost and the segment end fires only once
  assign len_eff = resync ? seg_len_nxt : seg_len_r;
  assign seg_end = enable_i & ~hs_req & tq_tick & (cnt_r + 1'b1 >= len_eff);

  // ==========================================================
  // Segment sequencer and quantum counter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_r     <= CBTR_SYNC;
      cnt_r     <= CBTR_CNT_RST;
      seg_len_r <= CBTR_SYNC_LEN;
    end else if (!enable_i || hs_req) begin  // see R2, R15
      // Hard sync: the edge quantum is the sync segment
      seg_r     <= CBTR_SYNC;
      cnt_r     <= CBTR_CNT_RST;
      seg_len_r <= CBTR_SYNC_LEN;
    end else begin
      // Resync corrects the running segment; a segment end below overrides it
      if (resync) begin  // see R2, R4
        seg_len_r <= seg_len_nxt;
      end
      if (seg_end) begin
        cnt_r <= CBTR_CNT_RST;  // see R15
        unique case (seg_r)  // see R1
          CBTR_SYNC: begin
            seg_r     <= CBTR_PROP;
            seg_len_r <= ext(prop_seg_i);  // see R5, R14
          end
          CBTR_PROP: begin
            seg_r     <= CBTR_PH1;
            seg_len_r <= ext(phase1_seg_i);  // see R14
          end
          CBTR_PH1: begin
            seg_r     <= CBTR_PH2;
            seg_len_r <= ext(phase2_seg_i);
          end
          CBTR_PH2: begin
            seg_r     <= CBTR_SYNC;
            seg_len_r <= CBTR_SYNC_LEN;
          end
        endcase
      end else if (tq_tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Sample, transmit and status outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_pin_o    <= CBTR_RECESSIVE;
      rx_bit_o    <= CBTR_RECESSIVE;
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
      phase_err_o <= 1'b0;
      hard_sync_o <= 1'b0;
      cfg_err_o   <= 1'b0;
    end else begin
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
      hard_sync_o <= hs_req;
      phase_err_o <= resync;  // see R4
      // Phase 2 within processing time and phase 1, sjw within phase 2
      cfg_err_o   <= (ext(phase2_seg_i) < CBTR_CNT_W'(CBTR_IPT_TQ)) |
                     (phase2_seg_i > phase1_seg_i) |
                     (sjw_i > phase2_seg_i);  // see R8, R9, R13
      // Same segment end as the sequencer, so pulses match its steps
      if (seg_end) begin
        if (seg_r == CBTR_PH1) begin
          rx_bit_o <= rx_sync_r;  // see R7
          sample_o <= 1'b1;
        end
        if (seg_r == CBTR_PH2) begin
          tx_pin_o    <= tx_bit_i;  // see R3
          bit_start_o <= 1'b1;
        end
      end else if (hs_req) begin
        bit_start_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  a_sample_once: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sample_o |=> !sample_o)  // see R7
    else $error("sample pulse longer than one cycle");
  a_tx_at_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(tx_pin_o) |-> bit_start_o)  // see R3
    else $error("transmit level changed away from bit start");
  a_sync_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hs_req && enable_i |=> seg_r == CBTR_SYNC && cnt_r == 0)  // see R2
    else $error("hard sync did not restart bit");
  a_ph1_grow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fall_edge && in_frame_i && seg_r == CBTR_PH1 && !hs_req && !seg_end
    |=> seg_len_r > $past(seg_len_r) || sjw_i == 0)  // see R10
    else $error("phase 1 not lengthened");
  a_ph2_limit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fall_edge && in_frame_i && seg_r == CBTR_PH2 && !seg_end
    |=> $past(seg_len_r) - seg_len_r <= CBTR_CNT_W'(sjw_i))  // see R11, R12
    else $error("phase 2 cut beyond jump width");
  a_perr_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fall_edge && in_frame_i && !in_sync_seg |=> phase_err_o)  // see R4
    else $error("phase error not flagged");
  a_cfg_check: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    phase2_seg_i < 2 ##1 $stable(phase2_seg_i) |-> cfg_err_o)  // see R9
    else $error("short phase 2 not flagged");
  a_seg_order: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seg_r == CBTR_PH1 && $past(seg_r) != CBTR_PH1 && !$past(hs_req)
    |-> $past(seg_r) == CBTR_PROP)  // see R1, R5
    else $error("phase 1 not after propagation");
  a_cnt_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(seg_r) |-> cnt_r == 0)  // see R15
    else $error("quantum counter not restarted");
  a_sample_point: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sample_o |-> seg_r == CBTR_PH2 && $past(seg_r) == CBTR_PH1)  // see R7
    else $error("sample not at end of phase 1");
  a_bit_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bit_start_o |-> seg_r == CBTR_SYNC && cnt_r == 0)  // see R1, R15
    else $error("bit start outside sync segment");
endmodule
`default_nettype wire

/* cbtr_bus_node.sv */
`timescale 1ns/1ps
`default_nettype none
// Remote node: after go, waits, then holds the bus dominant for a while
module cbtr_bus_node (
  input  wire logic       core_clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] wait_i,
  input  wire logic [7:0] len_i,
  output logic            bus_o
);
  int cnt = 0;
  // Dominant only inside the window, recessive pull-up otherwise
  always_ff @(posedge core_clk_i) begin
    if (go_i) cnt <= 1;
    else if (cnt != 0) cnt <= cnt + 1;
    if (cnt > wait_i && cnt <= wait_i + len_i) bus_o <= 1'b0;
    else bus_o <= 1'b1;
  end
endmodule
`default_nettype wire

/* test_can_bit_timing_resync.sv */
`timescale 1ns/1ps
`default_nettype none
module test_can_bit_timing_resync;
  import cbtr_pkg::*;
  logic       clk = 0, rst_n = 0, en = 0, frm = 0, txb = 1, go = 0;
  logic [7:0] prs = 8'h01, wt = 8'h00, ln = 8'h00;
  logic [3:0] p1 = 4'h4, p2 = 4'h4, sjw = 4'h2, pr = 4'h1;
  logic       tx, rxb, smp, bst, perr, hsy, cerr, node;
  int         failures = 0, samples_checked = 0;
  // ==========================================================
  // Clock, design and remote node on a wired-and bus
  initial forever #20 clk = ~clk;
  cbtr_bit_timing dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .enable_i(en),
    .prescale_i(prs), .prop_seg_i(pr), .phase1_seg_i(p1), .phase2_seg_i(p2),
    .sjw_i(sjw), .in_frame_i(frm), .tx_bit_i(txb), .rx_pin_i(node & tx),
    .tx_pin_o(tx), .rx_bit_o(rxb), .sample_o(smp), .bit_start_o(bst),
    .phase_err_o(perr), .hard_sync_o(hsy), .cfg_err_o(cerr));
  cbtr_bus_node node_u (.core_clk_i(clk), .go_i(go), .wait_i(wt), .len_i(ln),
    .bus_o(node));
  // ==========================================================
  // Compare, verdict and bit measurement helpers
  task check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cfg(input logic [3:0] a, input logic [3:0] b, input logic exp);
    @(posedge clk) p2 <= a;
    sjw <= b;
    repeat (2) @(negedge clk);
    check(cerr, exp);
  endtask
  task run_bit(input logic [7:0] w, input logic [7:0] l, output int n,
               output int sp, output logic pe);
    do @(negedge clk); while (bst !== 1'b1);
    @(posedge clk) go <= 1;
    wt <= w;
    ln <= l;
    @(posedge clk) go <= 0;
    n = 2;
    sp = 0;
    pe = 0;
    @(negedge clk);
    while (bst !== 1'b1 && n < 60) begin
      pe |= perr;
      if (smp === 1'b1) sp = n;
      n++;
      @(negedge clk);
    end
    // An edge that ends a cut bit flags in the bit start cycle
    pe |= perr;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int   n, sp;
    logic pe;
    fork
      begin
        #400000;
        failures++;
        give_verdict();
      end
    join_none
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    check(tx, 1'b1);
    check(rxb, 1'b1);
    cfg(4'h1, 4'h1, 1'b1);
    cfg(4'h5, 4'h2, 1'b1);
    cfg(4'h4, 4'h5, 1'b1);
    cfg(4'h4, 4'h2, 1'b0);
    @(posedge clk) en <= 1;
    go <= 1;
    wt <= 8'h01;
    ln <= 8'h08;
    @(posedge clk) go <= 0;
    pe = 0;
    repeat (12) begin
      @(negedge clk);
      pe |= hsy;
    end
    check(pe, 1'b1);
    @(posedge clk) frm <= 1;
    txb <= 0;
    repeat (2) do @(negedge clk); while (bst !== 1'b1);
    check(tx, 1'b0);
    @(posedge clk) txb <= 1;
    repeat (40) @(negedge clk);
    run_bit(8'hFF, 8'h00, n, sp, pe);
    check(8'(n), 8'h14);
    check(8'(sp), 8'h0C);
    check(rxb, 1'b1);
    run_bit(8'h04, 8'h1E, n, sp, pe);
    check(n > 20 && n <= 24, 1'b1);
    check(8'(sp), 8'h10);
    check(pe, 1'b1);
    check(rxb, 1'b0);
    repeat (40) @(negedge clk);
    run_bit(8'h0C, 8'h04, n, sp, pe);
    check(n >= 16 && n < 20, 1'b1);
    check(pe, 1'b1);
    @(posedge clk) pr <= 4'h3;
    run_bit(8'hFF, 8'h00, n, sp, pe);
    check(8'(n), 8'h18);
    check(8'(sp), 8'h10);
    give_verdict();
  end
endmodule
`default_nettype wire
